/* File: logic/pwm_pkg.sv */
// Constants of the enhanced PWM time base: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite master and a 20 MHz system clock on aclk.
`default_nettype none

package pwm_pkg;
    // Byte addresses of the register words
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_DUTY   = 6'h04;
    localparam logic [5:0] OFS_BUF    = 6'h08;
    localparam logic [5:0] OFS_PERIOD = 6'h0c;
    localparam logic [5:0] OFS_TIMER  = 6'h10;
    localparam logic [5:0] OFS_TCON   = 6'h14;
    localparam logic [5:0] OFS_FLAG   = 6'h18;
    localparam logic [5:0] OFS_DIR    = 6'h1c;
    localparam logic [5:0] OFS_STEER  = 6'h20;

    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic [3:0] RST_DIR    = 4'hf;
    localparam logic [3:0] RST_STEER  = 4'h1;

    localparam int TCON_RUN_BIT = 2;

    localparam logic [1:0] MMS_PWM   = 2'h3;
    localparam logic [1:0] OM_SINGLE = 2'h0;
    localparam logic [1:0] OM_FWD    = 2'h1;
    localparam logic [1:0] OM_HALF   = 2'h2;

    localparam logic [1:0] PS_SEL_1  = 2'h0;
    localparam logic [1:0] PS_SEL_4  = 2'h1;
    localparam logic [5:0] PS_LIM_1  = 6'h03;
    localparam logic [5:0] PS_LIM_4  = 6'h0f;
    localparam logic [5:0] PS_LIM_16 = 6'h3f;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwm_pkg

`default_nettype wire

/* File: logic/pwm_prescaler.sv */
// Prescaler for the period timer; yields the timer tick and low bits.
// Assumes run and hold come from flops in the same aclk domain.
`default_nettype none

module pwm_prescaler #(
    parameter int CNT_WIDTH = 6
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic       hold,
    input  wire logic [1:0] sel,
    output logic            tick,
    output logic [1:0]      low_bits
);
    typedef struct packed {
        logic [CNT_WIDTH-1:0] cnt;
        logic                 tick;
        logic [1:0]           low;
    } pre_state_type;

    if (CNT_WIDTH < 6)
    begin : g_chk
        $error("pwm_prescaler needs CNT_WIDTH of at least 6");
    end

    pre_state_type        s;
    pre_state_type        next_s;
    logic [CNT_WIDTH-1:0] lim;

    always_comb
    begin
        next_s = s;
        case (sel)
            pwm_pkg::PS_SEL_1: lim = CNT_WIDTH'(pwm_pkg::PS_LIM_1);
            pwm_pkg::PS_SEL_4: lim = CNT_WIDTH'(pwm_pkg::PS_LIM_4);
            default:           lim = CNT_WIDTH'(pwm_pkg::PS_LIM_16);
        endcase
        if (!run)
        begin
            next_s = '0;
        end
        else if (!hold)
        begin
            // Compare with >= so a smaller ratio chosen mid-count recovers
            if (s.cnt >= lim)
                next_s.cnt = '0;
            else
                next_s.cnt = s.cnt + 1'b1;
            // Tick marks the last sub-phase so the timer steps with low wrap
            next_s.tick = (next_s.cnt == lim);
            case (sel)
                pwm_pkg::PS_SEL_1: next_s.low = next_s.cnt[1:0];
                pwm_pkg::PS_SEL_4: next_s.low = next_s.cnt[3:2];
                default:           next_s.low = next_s.cnt[5:4];
            endcase
        end
        if (!aresetn)
            next_s = '0;
    end

    always_ff @(posedge aclk)
    begin
        s <= next_s;
    end

    assign tick     = s.tick;
    // Low bits lead by one edge so the owner's output flop can clear in
    // the very cycle in which the time base reaches the duty
    assign low_bits = next_s.low;

    AST_TICK_GAP: assert property (@(posedge aclk)
        disable iff (!aresetn || hold || !run)
        tick |=> (!tick) [*3])
        else $error("prescaler tick came sooner than four clocks");
endmodule : pwm_prescaler

`default_nettype wire

/* File: logic/pwm_timebase.sv */
// Enhanced PWM time base with bridge steering, behind an AXI4-Lite slave.
// Assumes one aclk domain, synchronous active-low reset, and that pin
// pads combine bridge_out with bridge_out_oe outside this block.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`default_nettype none

module pwm_timebase #(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  sleep_mode,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [3:0]                 bridge_out,
    output logic [3:0]                 bridge_out_oe,
    output logic [3:0]                 pwm_owns
);
    typedef struct packed {
        logic [7:0]            ctrl;
        logic [7:0]            duty_hi;
        logic [7:0]            duty_buf;
        logic [1:0]            duty_lat;
        logic [7:0]            pr;
        logic [7:0]            tmr;
        logic [2:0]            tcon;
        logic                  flag;
        logic [3:0]            dir;
        logic [3:0]            steer;
        logic                  started;
        logic                  level;
        logic [3:0]            out;
        logic [3:0]            oe;
        logic [3:0]            own;
        logic                  awready;
        logic                  wready;
        logic                  aw_full;
        logic                  w_full;
        logic [ADDR_WIDTH-1:0] awaddr;
        logic [7:0]            wbyte;
        logic                  wen;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [9:0]            rdata;
    } pwm_state_type;

    if (ADDR_WIDTH < 6)
    begin : g_chk
        $error("pwm_timebase needs ADDR_WIDTH of at least 6");
    end

    pwm_state_type s;
    pwm_state_type next_s;
    logic          tick;
    logic [1:0]    low_bits;
    logic          run;
    logic          go;
    logic          pwm_on;
    logic          boundary;
    logic          match;
    logic          mod;
    logic [3:0]    act;
    logic [3:0]    use_mask;
    logic [3:0]    pol;

    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                 input logic [5:0] ofs);
        hit = (a == ADDR_WIDTH'(ofs));
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_WIDTH-1:0] a);
        mapped = hit(a, pwm_pkg::OFS_CTRL) || hit(a, pwm_pkg::OFS_DUTY)
            || hit(a, pwm_pkg::OFS_BUF) || hit(a, pwm_pkg::OFS_PERIOD)
            || hit(a, pwm_pkg::OFS_TIMER) || hit(a, pwm_pkg::OFS_TCON)
            || hit(a, pwm_pkg::OFS_FLAG) || hit(a, pwm_pkg::OFS_DIR)
            || hit(a, pwm_pkg::OFS_STEER);
    endfunction : mapped

    // The system clock feeds the prescaler directly, so PWM rate tracks it
    pwm_prescaler #(
        .CNT_WIDTH (6)
    ) u_pre (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (run),
        .hold      (sleep_mode),
        .sel       (s.tcon[1:0]),
        .tick      (tick),
        .low_bits  (low_bits)
    );

    assign run = s.tcon[pwm_pkg::TCON_RUN_BIT];

    always_comb
    begin
        next_s = s;
        go = run && !sleep_mode;
        pwm_on = (s.ctrl[3:2] == pwm_pkg::MMS_PWM);
        boundary = go && tick && (s.tmr == s.pr);
        match = 1'b0;

        // Write address and data are taken independently
        if (s.awready && s_axi_awvalid)
        begin
            next_s.aw_full = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid)
        begin
            next_s.w_full = 1'b1;
            next_s.wbyte = s_axi_wdata[7:0];
            next_s.wen = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s.aw_full && s.w_full)
        begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(s.awaddr) ? pwm_pkg::RESP_OKAY
                                            : pwm_pkg::RESP_SLVERR;
            if (s.wen)
            begin
                if (hit(s.awaddr, pwm_pkg::OFS_CTRL))
                    next_s.ctrl = s.wbyte;
                if (hit(s.awaddr, pwm_pkg::OFS_DUTY))
                    next_s.duty_hi = s.wbyte;
                if (hit(s.awaddr, pwm_pkg::OFS_PERIOD))
                    next_s.pr = s.wbyte;
                if (hit(s.awaddr, pwm_pkg::OFS_TCON))
                    next_s.tcon = s.wbyte[2:0];
                // Flag is write-one-to-clear; a same-cycle set wins below
                if (hit(s.awaddr, pwm_pkg::OFS_FLAG))
                    next_s.flag = s.flag & ~s.wbyte[0];
                if (hit(s.awaddr, pwm_pkg::OFS_DIR))
                    next_s.dir = s.wbyte[3:0];
                if (hit(s.awaddr, pwm_pkg::OFS_STEER))
                    next_s.steer = s.wbyte[3:0];
            end
        end
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;

        // Reads answer one cycle after the address is taken
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s.arready && s_axi_arvalid)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = mapped(s_axi_araddr) ? pwm_pkg::RESP_OKAY
                                                : pwm_pkg::RESP_SLVERR;
            next_s.rdata = '0;
            if (hit(s_axi_araddr, pwm_pkg::OFS_CTRL))
                next_s.rdata[7:0] = s.ctrl;
            if (hit(s_axi_araddr, pwm_pkg::OFS_DUTY))
                next_s.rdata[7:0] = s.duty_hi;
            if (hit(s_axi_araddr, pwm_pkg::OFS_BUF))
                next_s.rdata = {s.duty_lat, s.duty_buf};
            if (hit(s_axi_araddr, pwm_pkg::OFS_PERIOD))
                next_s.rdata[7:0] = s.pr;
            if (hit(s_axi_araddr, pwm_pkg::OFS_TIMER))
                next_s.rdata[7:0] = s.tmr;
            if (hit(s_axi_araddr, pwm_pkg::OFS_TCON))
                next_s.rdata[2:0] = s.tcon;
            if (hit(s_axi_araddr, pwm_pkg::OFS_FLAG))
                next_s.rdata[0] = s.flag;
            if (hit(s_axi_araddr, pwm_pkg::OFS_DIR))
                next_s.rdata[3:0] = s.dir;
            if (hit(s_axi_araddr, pwm_pkg::OFS_STEER))
                next_s.rdata[3:0] = s.steer;
        end
        next_s.arready = !next_s.rvalid;

        // Waveform engine; sleep leaves every engine field as it was
        if (!sleep_mode)
        begin
            if (!pwm_on)
            begin
                next_s.started = 1'b0;
                next_s.level = 1'b0;
            end
            if (go && tick)
            begin
                if (boundary)
                begin
                    next_s.tmr = 8'h00;
                    next_s.flag = 1'b1;
                    next_s.duty_buf = s.duty_hi;
                    next_s.duty_lat = s.ctrl[5:4];
                    // Zero duty never raises the output
                    next_s.level = ({s.duty_hi, s.ctrl[5:4]} != 10'h000);
                    next_s.started = pwm_on;
                end
                else
                begin
                    next_s.tmr = s.tmr + 8'h01;
                end
            end
            // Compare the time base that stands after this edge, so the
            // output flop is already low while it equals the duty
            match = go && ({next_s.tmr, low_bits}
                           == {next_s.duty_buf, next_s.duty_lat});
            // A duty beyond the period never matches, so the pin holds
            if (match)
                next_s.level = 1'b0;
        end

        // Pin mapping per output mode; bits are d, c, b, a
        mod = next_s.started & next_s.level;
        case (next_s.ctrl[7:6])
            pwm_pkg::OM_SINGLE:
            begin
                act = {4{mod}};
                use_mask = next_s.steer;
            end
            pwm_pkg::OM_HALF:
            begin
                // No dead band here: B is the plain complement of A
                act = {2'b00, next_s.started & ~next_s.level, mod};
                use_mask = 4'h3;
            end
            pwm_pkg::OM_FWD:
            begin
                act = {mod, 1'b0, 1'b0, next_s.started};
                use_mask = 4'hf;
            end
            default:
            begin
                act = {1'b0, next_s.started, mod, 1'b0};
                use_mask = 4'hf;
            end
        endcase
        // Module mode bit 1 sets A and C active low, bit 0 sets B and D
        pol = {next_s.ctrl[0], next_s.ctrl[1],
               next_s.ctrl[0], next_s.ctrl[1]};
        if (next_s.ctrl[3:2] == pwm_pkg::MMS_PWM)
            next_s.own = use_mask;
        else
            next_s.own = 4'h0;
        next_s.out = (act ^ pol) & next_s.own;
        next_s.oe = next_s.own & ~next_s.dir;

        if (!aresetn)
        begin
            next_s = '0;
            next_s.pr = pwm_pkg::RST_PERIOD;
            next_s.dir = pwm_pkg::RST_DIR;
            next_s.steer = pwm_pkg::RST_STEER;
        end
    end

    always_ff @(posedge aclk)
    begin
        s <= next_s;
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rdata   = {22'h0, s.rdata};
    assign bridge_out    = s.out;
    assign bridge_out_oe = s.oe;
    assign pwm_owns      = s.own;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_DUTY_LOAD: assert property (
        boundary |=> (s.duty_buf == $past(s.duty_hi))
                     && (s.duty_lat == $past(s.ctrl[5:4])))
        else $error("duty buffer not loaded at period boundary");

    AST_TIMER_WRAP: assert property (
        boundary |=> (s.tmr == 8'h00) && s.flag)
        else $error("timer not cleared or flag not set at boundary");

    AST_SET_LEVEL: assert property (
        boundary |=> s.level == ($past({s.duty_hi, s.ctrl[5:4]}) != 10'h000))
        else $error("output level wrong after period boundary");

    AST_CLEAR_MATCH: assert property (
        (go && !boundary && match && !sleep_mode) |=> !s.level)
        else $error("output not cleared on duty match");

    AST_WIDE_DUTY: assert property (
        (go && !boundary && pwm_on && (s.tmr <= s.pr)
         && ({s.duty_buf, s.duty_lat} > {s.pr, 2'b11}))
        |=> s.level == $past(s.level))
        else $error("output changed although duty exceeds period");

    AST_SLEEP_FREEZE: assert property (
        sleep_mode |=> $stable(s.tmr) && $stable(s.level)
                       && $stable(s.started))
        else $error("engine state moved during sleep");

    AST_RELEASE: assert property (
        (s.ctrl == 8'h00) |-> (pwm_owns == 4'h0) && (bridge_out_oe == 4'h0))
        else $error("pins still owned with control register zero");

    AST_HALF_PINS: assert property (
        (pwm_on && s.ctrl[7:6] == pwm_pkg::OM_HALF) |-> pwm_owns == 4'h3)
        else $error("half bridge must own only outputs A and B");

    AST_HOLD_OFF: assert property (
        !s.started |-> bridge_out == ({s.ctrl[0], s.ctrl[1], s.ctrl[0],
                                       s.ctrl[1]} & pwm_owns))
        else $error("waveform driven before the first full period");

    AST_FWD_A: assert property (
        (pwm_on && s.started && s.ctrl[7:6] == pwm_pkg::OM_FWD)
        |-> bridge_out[0] == !s.ctrl[1])
        else $error("forward mode output A not at active level");

    AST_OE_OWNED: assert property (
        (bridge_out_oe & ~pwm_owns) == 4'h0)
        else $error("pin driven although not owned by the PWM block");

    AST_RESET_DIR: assert property (
        !$past(aresetn) |-> (s.dir == 4'hf) && (bridge_out_oe == 4'h0))
        else $error("pins not all inputs after reset");
endmodule : pwm_timebase

`default_nettype wire

/* File: verification/pwm_load_model.sv */
// Behavioural load on the four bridge pins, with an alternate function.
// Assumes bridge_out and bridge_out_oe come from the block in aclk domain.
`default_nettype none

module pwm_load_model (
    input  wire logic       aclk,
    input  wire logic [3:0] bridge_out,
    input  wire logic [3:0] bridge_out_oe,
    output logic      [3:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] alt_drive = 4'h0;

    // A released pin shows a pattern that moves every cycle, never a stale
    // copy of the last PWM level
    always @(posedge aclk)
    begin
        alt_drive <= ~alt_drive;
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pin_level[i] = bridge_out_oe[i] ? bridge_out[i]
                                            : alt_drive[i];
        end
    end
endmodule : pwm_load_model

`default_nettype wire

/* File: verification/tb_pwm_timebase.sv */
// Self-checking bench: AXI4-Lite register access and pin waveform counts.
// Assumes the pwm_pkg register map and a 20 MHz aclk.
`default_nettype none

module tb_pwm_timebase;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        sleep_mode = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  bridge_out, bridge_out_oe, pwm_owns, pin_level;
    int          errors = 0;
    int          cmp_count = 0;

    always #25 aclk = ~aclk;

    pwm_timebase #(.ADDR_WIDTH(8)) i_pwm_timebase (
        .aclk(aclk), .aresetn(aresetn), .sleep_mode(sleep_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .bridge_out(bridge_out), .bridge_out_oe(bridge_out_oe),
        .pwm_owns(pwm_owns)
    );

    pwm_load_model i_pwm_load_model (
        .aclk(aclk), .bridge_out(bridge_out),
        .bridge_out_oe(bridge_out_oe), .pin_level(pin_level)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    // Handshakes are judged at the falling edge, so the values seen are
    // the ones the next rising edge samples
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                             output logic [1:0] resp);
        logic aw_hs, w_hs, b_hs, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d};
        wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
        while (!done)
        begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            resp = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
            done = b_hs;
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        logic ar_hs, r_hs;
        r_hs = 1'b0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!r_hs)
        begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) rready <= 1'b0;
        end
    endtask : axi_read

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_write({2'h0, a}, d, r);
        check({30'h0, r}, {30'h0, pwm_pkg::RESP_OKAY});
    endtask : wr

    task automatic rd_check(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read({2'h0, a}, d, r);
        check(d, exp);
        check({30'h0, r}, {30'h0, pwm_pkg::RESP_OKAY});
    endtask : rd_check

    // High cycles seen on each pin over n cycles
    task automatic count4(input int n, output int c [4]);
        c = '{0, 0, 0, 0};
        repeat (n)
        begin
            @(negedge aclk);
            for (int i = 0; i < 4; i++)
                if (pin_level[i] === 1'b1) c[i]++;
        end
    endtask : count4

    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        complete_run();
    end

    initial
    begin
        logic [31:0] d, t1;
        logic [1:0]  r;
        logic [3:0]  pins_held;
        int          c [4];
        logic [5:0]  rst_ofs [9] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10,
                                     6'h14, 6'h18, 6'h1c, 6'h20};
        logic [7:0]  rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
                                     8'h00, 8'h00, 8'h0f, 8'h01};
        logic [1:0]  mcode [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
        logic [3:0]  own_exp [4] = '{4'h1, 4'h3, 4'hf, 4'hf};
        int          pin_exp [4][4] = '{'{4, 8, 8, 8}, '{4, 12, 8, 8},
                                        '{16, 0, 0, 4}, '{0, 4, 16, 0}};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd_check(rst_ofs[i], {24'h0, rst_val[i]});
        check({28'h0, bridge_out_oe}, 32'h0);
        axi_read(8'h24, d, r);
        check({30'h0, r}, {30'h0, pwm_pkg::RESP_SLVERR});
        axi_write(8'h24, 8'h5a, r);
        check({30'h0, r}, {30'h0, pwm_pkg::RESP_SLVERR});
        // Documented bring-up order; the block does not enforce it
        wr(pwm_pkg::OFS_DIR, 8'h0f);
        wr(pwm_pkg::OFS_PERIOD, 8'h00);
        wr(pwm_pkg::OFS_CTRL, 8'h2c);
        wr(pwm_pkg::OFS_DUTY, 8'h00);
        wr(pwm_pkg::OFS_FLAG, 8'h01);
        wr(pwm_pkg::OFS_TCON, 8'h04);
        d = 32'h0;
        while (d[0] !== 1'b1)
            axi_read({2'h0, pwm_pkg::OFS_FLAG}, d, r);
        wr(pwm_pkg::OFS_DIR, 8'h00);
        check({28'h0, pwm_owns}, 32'h1);
        rd_check(pwm_pkg::OFS_BUF, 32'h200);
        wr(pwm_pkg::OFS_BUF, 8'h33);
        rd_check(pwm_pkg::OFS_BUF, 32'h200);
        // Duty 2 of 4 counts at every prescale
        for (int p = 0; p < 3; p++)
        begin
            wr(pwm_pkg::OFS_TCON, 8'h04 | 8'(p));
            repeat (8 << (2 * p)) @(posedge aclk);
            count4(16 << (2 * p), c);
            check(32'(c[0]), 32'(8 << (2 * p)));
        end
        wr(pwm_pkg::OFS_TCON, 8'h04);
        wr(pwm_pkg::OFS_DUTY, 8'h01);
        repeat (8) @(posedge aclk);
        count4(16, c);
        check(32'(c[0]), 32'd16);
        wr(pwm_pkg::OFS_DUTY, 8'h00);
        wr(pwm_pkg::OFS_CTRL, 8'h0c);
        repeat (8) @(posedge aclk);
        count4(16, c);
        check(32'(c[0]), 32'd0);
        wr(pwm_pkg::OFS_CTRL, 8'h1e);
        repeat (8) @(posedge aclk);
        count4(16, c);
        check(32'(c[0]), 32'd12);
        for (int m = 0; m < 4; m++)
        begin
            wr(pwm_pkg::OFS_CTRL, {mcode[m], 6'h1c});
            repeat (16) @(posedge aclk);
            check({28'h0, pwm_owns}, {28'h0, own_exp[m]});
            count4(16, c);
            for (int i = 0; i < 4; i++)
                check(32'(c[i]), 32'(pin_exp[m][i]));
        end
        wr(pwm_pkg::OFS_CTRL, 8'h00);
        check({28'h0, pwm_owns}, 32'h0);
        check({28'h0, bridge_out_oe}, 32'h0);
        // A longer period makes the timer visible while frozen
        wr(pwm_pkg::OFS_CTRL, 8'h1c);
        wr(pwm_pkg::OFS_PERIOD, 8'h10);
        repeat (30) @(posedge aclk);
        sleep_mode <= 1'b1;
        @(posedge aclk);
        axi_read({2'h0, pwm_pkg::OFS_TIMER}, t1, r);
        pins_held = bridge_out;
        repeat (40) @(posedge aclk);
        rd_check(pwm_pkg::OFS_TIMER, t1);
        check({28'h0, bridge_out}, {28'h0, pins_held});
        sleep_mode <= 1'b0;
        repeat (20) @(posedge aclk);
        axi_read({2'h0, pwm_pkg::OFS_TIMER}, d, r);
        check(32'(d !== t1), 32'h1);
        complete_run();
    end
endmodule : tb_pwm_timebase

`default_nettype wire
